// ### rtl/aro_pkg.sv
`default_nettype none
package aro_pkg;

   // ---------------------------------------------------------------
   // conversion timing, in oscillator clocks
   // ---------------------------------------------------------------
   localparam logic [12:0] CYCLE_LAST  = 13'h1fff;
   localparam logic [12:0] INT_START   = 13'h0800;
   localparam logic [12:0] RAMP_START  = 13'h1000;
   localparam logic [12:0] HALT_BEFORE = 13'h0007;
   localparam logic [12:0] HALT_POINT  = INT_START - HALT_BEFORE;
   localparam logic [12:0] CNT_RST     = 13'h0000;

   // ---------------------------------------------------------------
   // register map and fields
   // ---------------------------------------------------------------
   localparam logic [11:0] CTRL_OFS    = 12'h000;
   localparam logic [11:0] STAT_OFS    = 12'h004;
   localparam logic [11:0] RESULT_OFS  = 12'h008;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {PH_ZERO, PH_INT, PH_RAMP} aro_phase_type;

   typedef enum logic [1:0] {HS_IDLE, HS_HIGH, HS_LOW} aro_hs_type;

   typedef struct packed {
      logic        overrange;
      logic        sign_flag;
      logic [11:0] magnitude;
   } aro_result_type;

   typedef struct packed {
      logic force_ones;
      logic run_en;
   } aro_ctrl_type;

   typedef struct packed {
      logic          hs_mode;
      logic          hs_busy;
      aro_phase_type phase;
      logic          conv_status;
   } aro_stat_type;

   typedef struct packed {
      logic run_hold;
      logic mode;
      logic test_n;
      logic send;
      logic cmp_pos;
      logic ce_n;
      logic low_en_n;
      logic high_en_n;
   } aro_pins_type;

   localparam aro_ctrl_type   CTRL_RST   = 2'h1;
   localparam aro_result_type RESULT_RST = 14'h0000;
   // idle pin levels; mode resets low so release is no false mode edge
   localparam aro_pins_type   PINS_RST   = 8'hbf;

endpackage
`default_nettype wire

// ### rtl/aro_axil_regs.sv
`timescale 1ns/1ps
`default_nettype none
module aro_axil_regs
(
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   input  wire logic [31:0]             s_axi_awaddr,
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   input  wire logic [31:0]             s_axi_wdata,
   input  wire logic [3:0]              s_axi_wstrb,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   output logic [1:0]                   s_axi_bresp,
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   input  wire logic [31:0]             s_axi_araddr,
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   output logic [31:0]                  s_axi_rdata,
   output logic [1:0]                   s_axi_rresp,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready,
   output aro_pkg::aro_ctrl_type        ctrl,
   input  wire aro_pkg::aro_stat_type   stat,
   input  wire aro_pkg::aro_result_type result
);

   // ---------------------------------------------------------------
   // write path: address and data caught in either order
   // ---------------------------------------------------------------
   logic                  aw_full_ff, nxt_aw_full;
   logic [11:0]           aw_addr_ff, nxt_aw_addr;
   logic                  w_full_ff, nxt_w_full;
   logic [31:0]           w_data_ff, nxt_w_data;
   logic                  w_strb0_ff, nxt_w_strb0;
   logic                  bvalid_ff, nxt_bvalid;
   logic [1:0]            bresp_ff, nxt_bresp;
   aro_pkg::aro_ctrl_type ctrl_ff, nxt_ctrl;

   assign s_axi_awready = !aw_full_ff && !bvalid_ff;
   assign s_axi_wready  = !w_full_ff && !bvalid_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign ctrl          = ctrl_ff;

   always_comb
   begin
      nxt_aw_full = aw_full_ff;
      nxt_aw_addr = aw_addr_ff;
      nxt_w_full  = w_full_ff;
      nxt_w_data  = w_data_ff;
      nxt_w_strb0 = w_strb0_ff;
      nxt_bvalid  = bvalid_ff;
      nxt_bresp   = bresp_ff;
      nxt_ctrl    = ctrl_ff;
      if (s_axi_awvalid && s_axi_awready)
      begin
         nxt_aw_full = 1'b1;
         nxt_aw_addr = s_axi_awaddr[11:0];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         nxt_w_full  = 1'b1;
         nxt_w_data  = s_axi_wdata;
         nxt_w_strb0 = s_axi_wstrb[0];
      end
      if (aw_full_ff && w_full_ff && !bvalid_ff)
      begin
         nxt_aw_full = 1'b0;
         nxt_w_full  = 1'b0;
         nxt_bvalid  = 1'b1;
         nxt_bresp   = aro_pkg::RESP_OKAY;
         if (aw_addr_ff == aro_pkg::CTRL_OFS)
         begin
            if (w_strb0_ff)
            begin
               nxt_ctrl = w_data_ff[1:0];
            end
         end
         else if (aw_addr_ff != aro_pkg::STAT_OFS &&
                  aw_addr_ff != aro_pkg::RESULT_OFS)
         begin
            nxt_bresp = aro_pkg::RESP_SLVERR;
         end
      end
      if (bvalid_ff && s_axi_bready)
      begin
         nxt_bvalid = 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------
   logic        rvalid_ff, nxt_rvalid;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [1:0]  rresp_ff, nxt_rresp;

   assign s_axi_arready = !rvalid_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = rresp_ff;

   always_comb
   begin
      nxt_rvalid = rvalid_ff;
      nxt_rdata  = rdata_ff;
      nxt_rresp  = rresp_ff;
      if (s_axi_arvalid && s_axi_arready)
      begin
         nxt_rvalid = 1'b1;
         nxt_rresp  = aro_pkg::RESP_OKAY;
         case (s_axi_araddr[11:0])
            aro_pkg::CTRL_OFS:   nxt_rdata = {30'h00000000, ctrl_ff};
            aro_pkg::STAT_OFS:   nxt_rdata = {27'h0000000, stat};
            aro_pkg::RESULT_OFS: nxt_rdata = {18'h00000, result};
            default:
            begin
               nxt_rdata = 32'h00000000;
               nxt_rresp = aro_pkg::RESP_SLVERR;
            end
         endcase
      end
      else if (rvalid_ff && s_axi_rready)
      begin
         nxt_rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_full_ff <= 1'b0;
         aw_addr_ff <= 12'h000;
         w_full_ff  <= 1'b0;
         w_data_ff  <= 32'h00000000;
         w_strb0_ff <= 1'b0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= aro_pkg::RESP_OKAY;
         ctrl_ff    <= aro_pkg::CTRL_RST;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= 32'h00000000;
         rresp_ff   <= aro_pkg::RESP_OKAY;
      end
      else
      begin
         aw_full_ff <= nxt_aw_full;
         aw_addr_ff <= nxt_aw_addr;
         w_full_ff  <= nxt_w_full;
         w_data_ff  <= nxt_w_data;
         w_strb0_ff <= nxt_w_strb0;
         bvalid_ff  <= nxt_bvalid;
         bresp_ff   <= nxt_bresp;
         ctrl_ff    <= nxt_ctrl;
         rvalid_ff  <= nxt_rvalid;
         rdata_ff   <= nxt_rdata;
         rresp_ff   <= nxt_rresp;
      end
   end

endmodule
`default_nettype wire

// ### rtl/aro_port.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - result is 12-bit magnitude, sign, overrange
// - status high in integrate phases, low auto-zero
// - sign high positive, overrange beyond full scale
// - bit 12 msb; outputs three-state, active high
// - force-ones input low drives all bits high
// - direct mode: low byte enabled by enables
// - direct mode: high byte enabled by enables
// - direct mode: chip enable high floats all data outputs
// - mode low: enable pins are host inputs
// - mode high: pins become flags, send on completion
// - mode pulse sends latest result immediately
// - 8192-clock cycle; hold stops 7 before integrate
// - signal integrate lasts 2048 clocks, then polarity
module aro_port
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        run_enable,
   input  wire logic        handshake_mode,
   input  wire logic        force_ones_n,
   input  wire logic        transmit_permit,
   input  wire logic        comparator_pos,
   input  wire logic        chip_enable_n_pin,
   output logic             chip_enable_n_drv,
   output logic             chip_enable_n_oe,
   input  wire logic        low_byte_enable_n_pin,
   output logic             low_byte_enable_n_drv,
   output logic             low_byte_enable_n_oe,
   input  wire logic        high_byte_enable_n_pin,
   output logic             high_byte_enable_n_drv,
   output logic             high_byte_enable_n_oe,
   output logic [11:0]      result_bits,
   output logic             sign_flag,
   output logic             overrange,
   output logic             low_byte_oe,
   output logic             high_byte_oe,
   output logic             conv_status
);

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   aro_pkg::aro_pins_type sync1_ff, sync2_ff, nxt_sync1;
   aro_pkg::aro_pins_type pins;

   always_comb
   begin
      nxt_sync1 = {run_enable, handshake_mode, force_ones_n,
                   transmit_permit, comparator_pos, chip_enable_n_pin,
                   low_byte_enable_n_pin, high_byte_enable_n_pin};
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sync1_ff <= aro_pkg::PINS_RST;
         sync2_ff <= aro_pkg::PINS_RST;
      end
      else
      begin
         sync1_ff <= nxt_sync1;
         sync2_ff <= sync1_ff;
      end
   end

   assign pins = sync2_ff;

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   aro_pkg::aro_ctrl_type   ctrl;
   aro_pkg::aro_stat_type   stat;
   aro_pkg::aro_result_type hold_ff, nxt_hold;
   aro_pkg::aro_hs_type     hs_ff, nxt_hs;

   aro_axil_regs u_regs
   (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .ctrl          (ctrl),
      .stat          (stat),
      .result        (hold_ff)
   );

   // ---------------------------------------------------------------
   // conversion sequencer
   // ---------------------------------------------------------------
   function automatic aro_pkg::aro_phase_type phase_of(logic [12:0] c);
      if (c < aro_pkg::INT_START)
         phase_of = aro_pkg::PH_ZERO;
      else if (c < aro_pkg::RAMP_START)
         phase_of = aro_pkg::PH_INT;
      else
         phase_of = aro_pkg::PH_RAMP;
   endfunction

   logic [12:0] cnt_ff, nxt_cnt;
   logic        sign_ff, nxt_sign;
   logic        crossed_ff, nxt_crossed;
   logic [11:0] mag_ff, nxt_mag;
   logic        status_ff, nxt_status;
   logic        done_ff, nxt_done;
   logic        mode_d_ff;
   logic        run_eff;
   logic        halted;

   assign run_eff = pins.run_hold && ctrl.run_en;

   always_comb
   begin
      nxt_cnt     = cnt_ff;
      nxt_sign    = sign_ff;
      nxt_crossed = crossed_ff;
      nxt_mag     = mag_ff;
      nxt_hold    = hold_ff;
      halted = (cnt_ff == aro_pkg::HALT_POINT) && !run_eff;
      if (!halted)
      begin
         nxt_cnt = cnt_ff + 13'h0001;
      end
      if (cnt_ff == aro_pkg::RAMP_START - 13'h0001)
      begin
         nxt_sign    = pins.cmp_pos;
         nxt_crossed = 1'b0;
         nxt_mag     = 12'h000;
      end
      else if (phase_of(cnt_ff) == aro_pkg::PH_RAMP && !crossed_ff &&
               pins.cmp_pos != sign_ff)
      begin
         nxt_crossed = 1'b1;
         nxt_mag     = cnt_ff[11:0];
      end
      if (cnt_ff == aro_pkg::CYCLE_LAST)
      begin
         nxt_hold.overrange = !crossed_ff;
         nxt_hold.sign_flag = sign_ff;
         nxt_hold.magnitude = mag_ff;
      end
      nxt_status = phase_of(nxt_cnt) != aro_pkg::PH_ZERO;
      nxt_done   = cnt_ff == aro_pkg::CYCLE_LAST;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cnt_ff     <= aro_pkg::CNT_RST;
         sign_ff    <= 1'b0;
         crossed_ff <= 1'b0;
         mag_ff     <= 12'h000;
         hold_ff    <= aro_pkg::RESULT_RST;
         status_ff  <= 1'b0;
         done_ff    <= 1'b0;
         mode_d_ff  <= 1'b0;
      end
      else
      begin
         cnt_ff     <= nxt_cnt;
         sign_ff    <= nxt_sign;
         crossed_ff <= nxt_crossed;
         mag_ff     <= nxt_mag;
         hold_ff    <= nxt_hold;
         status_ff  <= nxt_status;
         done_ff    <= nxt_done;
         mode_d_ff  <= pins.mode;
      end
   end

   // ---------------------------------------------------------------
   // handshake sender
   // ---------------------------------------------------------------
   logic hs_start;

   assign hs_start = (pins.mode && !mode_d_ff) || (done_ff && pins.mode);

   always_comb
   begin
      nxt_hs = hs_ff;
      case (hs_ff)
         aro_pkg::HS_IDLE: if (hs_start) nxt_hs = aro_pkg::HS_HIGH;
         aro_pkg::HS_HIGH: if (pins.send) nxt_hs = aro_pkg::HS_LOW;
         aro_pkg::HS_LOW:  if (pins.send) nxt_hs = aro_pkg::HS_IDLE;
         default:          nxt_hs = aro_pkg::HS_IDLE;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         hs_ff <= aro_pkg::HS_IDLE;
      else
         hs_ff <= nxt_hs;
   end

   // ---------------------------------------------------------------
   // output drivers
   // ---------------------------------------------------------------
   aro_pkg::aro_result_type data_ff, nxt_data;
   logic                    force_all;
   logic                    hs_on;

   assign force_all = !pins.test_n || ctrl.force_ones;
   assign hs_on     = hs_ff != aro_pkg::HS_IDLE;

   always_comb
   begin
      nxt_data = hold_ff;
      if (force_all)
      begin
         nxt_data.magnitude = 12'hfff;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         data_ff <= aro_pkg::RESULT_RST;
      else
         data_ff <= nxt_data;
   end

   assign result_bits = data_ff.magnitude;
   assign sign_flag   = data_ff.sign_flag;
   assign overrange   = data_ff.overrange;

   assign low_byte_oe  = pins.mode ? (hs_ff == aro_pkg::HS_LOW)
                                   : (!pins.ce_n && !pins.low_en_n);
   assign high_byte_oe = pins.mode ? (hs_ff == aro_pkg::HS_HIGH)
                                   : (!pins.ce_n && !pins.high_en_n);

   assign chip_enable_n_oe       = pins.mode;
   assign low_byte_enable_n_oe   = pins.mode;
   assign high_byte_enable_n_oe  = pins.mode;
   // load strobe only while receiver permits
   assign chip_enable_n_drv      = !(hs_on && pins.send);
   assign low_byte_enable_n_drv  = hs_ff != aro_pkg::HS_LOW;
   assign high_byte_enable_n_drv = hs_ff != aro_pkg::HS_HIGH;
   assign conv_status            = status_ff;

   assign stat = {pins.mode, hs_on, phase_of(cnt_ff), status_ff};

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   property p_status_drop;
      @(posedge aclk) disable iff (!aresetn)
      $rose(done_ff) |-> !status_ff && $past(status_ff);
   endproperty
   a_status_drop: assert property (p_status_drop)
      else $error("status not dropped at latch");

   property p_int_len;
      @(posedge aclk) disable iff (!aresetn)
      (phase_of(cnt_ff) == aro_pkg::PH_INT) |=>
         (phase_of(cnt_ff) == aro_pkg::PH_INT) ||
         (cnt_ff == aro_pkg::RAMP_START);
   endproperty
   a_int_len: assert property (p_int_len)
      else $error("integrate phase cut short");

   property p_period;
      @(posedge aclk) disable iff (!aresetn)
      (cnt_ff == aro_pkg::CYCLE_LAST) |=> (cnt_ff == aro_pkg::CNT_RST);
   endproperty
   a_period: assert property (p_period)
      else $error("cycle did not wrap");

   property p_halt;
      @(posedge aclk) disable iff (!aresetn)
      (cnt_ff == aro_pkg::HALT_POINT && !run_eff) |=>
         (cnt_ff == aro_pkg::HALT_POINT) && !status_ff;
   endproperty
   a_halt: assert property (p_halt)
      else $error("hold point not kept");

   property p_force;
      @(posedge aclk) disable iff (!aresetn)
      force_all |=> (result_bits == 12'hfff);
   endproperty
   a_force: assert property (p_force)
      else $error("force ones not applied");

   property p_ce_off;
      @(posedge aclk) disable iff (!aresetn)
      (!pins.mode && pins.ce_n) |-> !low_byte_oe && !high_byte_oe;
   endproperty
   a_ce_off: assert property (p_ce_off)
      else $error("data driven with chip enable high");

   property p_low_en;
      @(posedge aclk) disable iff (!aresetn)
      (!pins.mode && !pins.ce_n && !pins.low_en_n) |-> low_byte_oe;
   endproperty
   a_low_en: assert property (p_low_en)
      else $error("low byte not enabled");

   property p_high_en;
      @(posedge aclk) disable iff (!aresetn)
      (!pins.mode && !pins.ce_n && !pins.high_en_n) |-> high_byte_oe;
   endproperty
   a_high_en: assert property (p_high_en)
      else $error("high byte not enabled");

   property p_latch;
      @(posedge aclk) disable iff (!aresetn)
      (hold_ff != $past(hold_ff)) |-> $past(cnt_ff) == aro_pkg::CYCLE_LAST;
   endproperty
   a_latch: assert property (p_latch)
      else $error("result changed outside completion");

   property p_flags;
      @(posedge aclk) disable iff (!aresetn)
      done_ff |-> hold_ff.overrange == !$past(crossed_ff) &&
                  hold_ff.sign_flag == $past(sign_ff);
   endproperty
   a_flags: assert property (p_flags)
      else $error("sign or overrange flag wrong");

   property p_hs_start;
      @(posedge aclk) disable iff (!aresetn)
      (hs_ff == aro_pkg::HS_IDLE && pins.mode && (!mode_d_ff || done_ff))
         |=> (hs_ff == aro_pkg::HS_HIGH) ##0 !high_byte_enable_n_drv;
   endproperty
   a_hs_start: assert property (p_hs_start)
      else $error("handshake did not start");

   property p_hs_order;
      @(posedge aclk) disable iff (!aresetn)
      (hs_ff == aro_pkg::HS_HIGH && pins.send) |->
         !chip_enable_n_drv ##1 (hs_ff == aro_pkg::HS_LOW && low_byte_oe);
   endproperty
   a_hs_order: assert property (p_hs_order)
      else $error("byte order broken");

   property p_direct_in;
      @(posedge aclk) disable iff (!aresetn)
      !pins.mode |-> !chip_enable_n_oe && !low_byte_enable_n_oe;
   endproperty
   a_direct_in: assert property (p_direct_in)
      else $error("enable pins driven in direct mode");

endmodule
`default_nettype wire

// ### bench/aro_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
module aro_rx_model
(
   input  wire logic       aclk,
   input  wire logic       stall,
   input  wire logic       load_n,
   input  wire logic       hflag_n,
   input  wire logic       lflag_n,
   input  wire logic [7:0] bus,
   output logic            permit,
   output logic [7:0]      hb,
   output logic [7:0]      lb,
   output logic [3:0]      loads
);
   initial
   begin
      permit = 1'b1;
      hb = 8'h00;
      lb = 8'h00;
      loads = 4'h0;
   end
   always @(posedge aclk)
   begin
      permit <= !stall;
      if (!load_n && permit)
      begin
         loads <= loads + 4'h1;
         if (!hflag_n)
            hb <= bus;
         if (!lflag_n)
            lb <= bus;
      end
   end
endmodule
`default_nettype wire

// ### bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
 $display("FAIL t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
   logic        aclk, aresetn, run, mode, force_n, comp, stall, permit;
   logic        awvalid, wvalid, bready, arvalid, rready, ce_h, lb_h, hb_h;
   logic [31:0] awaddr, wdata, araddr, rdata, d;
   logic        awready, wready, bvalid, arready, rvalid, stat;
   logic [1:0]  bresp, rresp, r;
   logic        ce_d, ce_oe, lb_d, lb_oe, hb_d, hb_oe, sgn, ovr, lo_oe, hi_oe;
   logic [11:0] bits;
   logic [7:0]  hb, lb;
   logic [3:0]  loads;
   int          err_count, compares, i;
   // -----------------------------------------------------------------
   // design and receiver
   // -----------------------------------------------------------------
   aro_port dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .run_enable(run),
      .handshake_mode(mode), .force_ones_n(force_n),
      .transmit_permit(permit), .comparator_pos(comp),
      .chip_enable_n_pin(ce_oe ? ce_d : ce_h), .chip_enable_n_drv(ce_d),
      .chip_enable_n_oe(ce_oe), .low_byte_enable_n_pin(lb_oe ? lb_d : lb_h),
      .low_byte_enable_n_drv(lb_d), .low_byte_enable_n_oe(lb_oe),
      .high_byte_enable_n_pin(hb_oe ? hb_d : hb_h),
      .high_byte_enable_n_drv(hb_d), .high_byte_enable_n_oe(hb_oe),
      .result_bits(bits), .sign_flag(sgn), .overrange(ovr),
      .low_byte_oe(lo_oe), .high_byte_oe(hi_oe), .conv_status(stat));
   aro_rx_model rx (.aclk(aclk), .stall(stall),
      .load_n(ce_oe ? ce_d : 1'b1), .hflag_n(hb_oe ? hb_d : 1'b1),
      .lflag_n(lb_oe ? lb_d : 1'b1),
      .bus(!hb_d ? {2'b00, ovr, sgn, bits[11:8]} : bits[7:0]),
      .permit(permit), .hb(hb), .lb(lb), .loads(loads));
   initial
   begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   // -----------------------------------------------------------------
   // bus and wait tasks
   // -----------------------------------------------------------------
   task automatic report_and_stop;
      $display("err_count=%0d compares=%0d", err_count, compares);
      if (err_count == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic fail_wait;
      err_count++;
      report_and_stop;
   endtask
   task automatic axw(input logic [31:0] a, input logic [31:0] v);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 50 && !bvalid; i++)
      begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end
      if (!bvalid)
         fail_wait;
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic axr(input logic [31:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 50 && !rvalid; i++)
      begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'b0;
      end
      if (!rvalid)
         fail_wait;
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask
   // status level reached within one full conversion, else timeout
   task automatic until_stat(input logic v);
      for (i = 0; i < 9000 && stat !== v; i++) @(posedge aclk);
      if (stat !== v)
         fail_wait;
   endtask
   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   initial
   begin
      {aresetn, mode, stall, awvalid, wvalid, bready, arvalid, rready} = 0;
      {run, force_n, comp, ce_h, lb_h, hb_h} = 6'h3f;
      {awaddr, wdata, araddr} = 0;
      err_count = 0;
      compares = 0;
      wt(6);
      aresetn <= 1'b1;
      wt(1);
      axr(32'h0);
      `CHK(d[0], 1'b1)
      axr(32'hc);
      `CHK(r, aro_pkg::RESP_SLVERR)
      axw(32'h0, 32'h1);
      `CHK(r, aro_pkg::RESP_OKAY)
      until_stat(1'b1);
      wt(2148);
      comp <= 1'b0;
      until_stat(1'b0);
      wt(4);
      {ce_h, lb_h, hb_h} <= 3'h0;
      wt(4);
      `CHK({lo_oe, hi_oe, sgn, ovr}, 4'he)
      `CHK(bits > 12'd94 && bits < 12'd110, 1'b1)
      hb_h <= 1'b1;
      wt(4);
      `CHK({lo_oe, hi_oe}, 2'h2)
      {lb_h, hb_h} <= 2'h2;
      wt(4);
      `CHK({lo_oe, hi_oe}, 2'h1)
      ce_h <= 1'b1;
      wt(4);
      `CHK({lo_oe, hi_oe}, 2'h0)
      force_n <= 1'b0;
      wt(4);
      `CHK(bits, 12'hfff)
      force_n <= 1'b1;
      wt(4);
      d[11:0] = bits;
      until_stat(1'b1);
      wt(3000);
      `CHK(bits, d[11:0])
      until_stat(1'b0);
      wt(4);
      `CHK({sgn, ovr, bits}, 14'h1000)
      stall <= 1'b1;
      mode <= 1'b1;
      wt(10);
      `CHK({loads, hb_d, hb_oe}, 6'h01)
      stall <= 1'b0;
      wt(10);
      `CHK({loads, hb, lb}, 20'h22000)
      until_stat(1'b1);
      until_stat(1'b0);
      wt(10);
      `CHK(loads, 4'h4)
      run <= 1'b0;
      mode <= 1'b0;
      wt(11000);
      axr(32'h4);
      `CHK(d[2:0], 3'h0)
      run <= 1'b1;
      for (i = 0; i < 20 && stat !== 1'b1; i++) @(posedge aclk);
      `CHK(i >= 7 && i <= 12, 1'b1)
      for (i = 0; i < 7000 && stat === 1'b1; i++) @(posedge aclk);
      `CHK(i >= 6142 && i <= 6146, 1'b1)
      report_and_stop;
   end
endmodule
`default_nettype wire
